// [bba_adder.sv]
// decimal/binary byte adder with carry trigger, behind an ahb-lite slave
//
// Behaviour
// - eight-bit binary adder, two eight-bit inputs, result held in output latches.
// - carry out of top position stored; used as carry in for next byte.
// - positions 0-3 form high digit, 4-7 low digit, each gated independently.
// - left byte feeds adder directly; right byte only through plus-six stage.
// - usable as latched byte or digit pass path, binary or decimal, or adder.
// - binary pass-through leaves every data bit unchanged in the output latches while the carry trigger is clear; a set trigger adds one.
// - decimal-true digits get plus six, forcing carry when digit sum exceeds nine.
// - digit with carry out passes; digit without carry has six subtracted.
// - output correction only on digits gated decimal; binary digits uncorrected.
// - each right digit has own complement control inverting its four bits.
// - decimal subtraction adds no six; ones' complement serves both subtractions.
// - subtraction uses the same per-digit output correction as addition.
// - per-digit unaltered controls pass digit as is, mixable with decimal gating.
// - invert-sign flips only bit position seven of the right low digit.
// - each adder cycle compares half-sum parity to inverted input parity xor.
`timescale 1ns/100ps
`default_nettype none
module bba_adder
    import bba_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic      [7:0]  sum_byte,
    output logic             carry_trigger
);
    logic [BBA_CTRL_W-1:0] ctrl_q;
    logic [17:0]           oper_q;
    logic [7:0]            result_q;
    logic                  carry_q;
    logic                  hcy_q;
    logic                  lcy_q;
    logic [BBA_EVT_W-1:0]  status_q;
    logic [BBA_EVT_W-1:0]  mask_q;
    logic                  op_go_q;
    logic                  wr_pend_q;
    logic [7:0]            wr_addr_q;
    logic [31:0]           hrdata_q;
    logic                  irq_q;
    logic                  addr_take;
    logic                  wr_data;
    logic [7:0]            left_byte;
    logic [7:0]            right_byte;
    logic [7:0]            corr_byte;
    logic                  lo_cout;
    logic                  hi_cout;
    logic                  hs_err;
    logic [BBA_EVT_W-1:0]  evt_set;
    logic [BBA_EVT_W-1:0]  evt_clr;
    logic [31:0]           rd_mux;

    // hsize is unused: only aligned whole-word transfers are served
    assign addr_take = clk_en && hsel && htrans[1] && hready;
    assign wr_data   = clk_en && wr_pend_q;

    // bit position 0 of the byte is the msb, so position 7 is verilog bit 0
    assign left_byte  = oper_q[BBA_OPER_LEFT_LSB +: 8];
    assign right_byte = {oper_q[BBA_OPER_RIGHT_LSB+7 : BBA_OPER_RIGHT_LSB+1],
                         oper_q[BBA_OPER_RIGHT_LSB] ^ ctrl_q[BBA_INV_SIGN_BIT]};

    // low digit (positions 4-7) takes the stored carry, high digit the low carry
    bba_digit #(.W(4)) u_low_digit (
        .left_digit   (left_byte[3:0]),
        .right_digit  (right_byte[3:0]),
        .left_gate    (ctrl_q[BBA_LLO_GATE_BIT]),
        .right_gate   (ctrl_q[BBA_RLO_GATE_BIT]),
        .decimal_true (ctrl_q[BBA_LO_DEC_BIT]),
        .complement   (ctrl_q[BBA_LO_COMP_BIT]),
        .unaltered    (ctrl_q[BBA_LO_BIN_BIT]),
        .carry_in     (carry_q),
        .sum_out      (corr_byte[3:0]),
        .carry_out    (lo_cout)
    );

    bba_digit #(.W(4)) u_high_digit (
        .left_digit   (left_byte[7:4]),
        .right_digit  (right_byte[7:4]),
        .left_gate    (ctrl_q[BBA_LHI_GATE_BIT]),
        .right_gate   (ctrl_q[BBA_RHI_GATE_BIT]),
        .decimal_true (ctrl_q[BBA_HI_DEC_BIT]),
        .complement   (ctrl_q[BBA_HI_COMP_BIT]),
        .unaltered    (ctrl_q[BBA_HI_BIN_BIT]),
        .carry_in     (lo_cout),
        .sum_out      (corr_byte[7:4]),
        .carry_out    (hi_cout)
    );

    // checked on the raw gate bytes; parity adjust for partial bytes is not modelled
    bba_hs_check #(.W(8)) u_hs_check (
        .left_byte    (left_byte),
        .right_byte   (oper_q[BBA_OPER_RIGHT_LSB +: 8]),
        .left_parity  (oper_q[BBA_OPER_LPAR_BIT]),
        .right_parity (oper_q[BBA_OPER_RPAR_BIT]),
        .hs_error     (hs_err)
    );

    // bus address phase
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (clk_en) begin
            wr_pend_q <= addr_take && hwrite;
            if (addr_take) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            BBA_CTRL_OFS:   rd_mux[BBA_CTRL_W-1:0] = ctrl_q;
            BBA_OPER_OFS:   rd_mux[17:0] = oper_q;
            BBA_RESULT_OFS: rd_mux[10:0] = {lcy_q, hcy_q, carry_q, result_q};
            BBA_STATUS_OFS: rd_mux[BBA_EVT_W-1:0] = status_q;
            BBA_MASK_OFS:   rd_mux[BBA_EVT_W-1:0] = mask_q;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata_q <= rd_mux;
        end
    end

    // zero-wait slave, response always okay
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // software registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_q <= BBA_CTRL_RST;
            oper_q <= BBA_OPER_RST;
            mask_q <= BBA_EVT_RST;
        end else if (wr_data) begin
            if (wr_addr_q == BBA_CTRL_OFS) begin
                ctrl_q <= hwdata[BBA_CTRL_W-1:0];
            end
            if (wr_addr_q == BBA_OPER_OFS) begin
                oper_q <= hwdata[17:0];
            end
            if (wr_addr_q == BBA_MASK_OFS) begin
                mask_q <= hwdata[BBA_EVT_W-1:0];
            end
        end
    end

    // a command write with the go bit set starts exactly one adder cycle on the next edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            op_go_q <= 1'b0;
        end else if (clk_en) begin
            op_go_q <= wr_data && (wr_addr_q == BBA_CMD_OFS) && hwdata[BBA_CMD_GO_BIT];
        end
    end

    // output latches and carry trigger; clear/preset lands before a go in the same write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result_q <= 8'h00;
            carry_q  <= 1'b0;
            hcy_q    <= 1'b0;
            lcy_q    <= 1'b0;
        end else if (clk_en) begin
            if (op_go_q) begin
                result_q <= corr_byte;
                carry_q  <= hi_cout;
                hcy_q    <= hi_cout;
                lcy_q    <= lo_cout;
            end else if (wr_data && (wr_addr_q == BBA_CMD_OFS)) begin
                if (hwdata[BBA_CMD_SET_BIT]) begin
                    carry_q <= 1'b1;
                end else if (hwdata[BBA_CMD_CLR_BIT]) begin
                    carry_q <= 1'b0;
                end
            end
        end
    end

    // sticky events, write one to clear, a new event beats its own clear
    always_comb begin
        evt_set = '0;
        evt_set[BBA_EVT_DONE_BIT] = op_go_q;
        evt_set[BBA_EVT_HS_BIT]   = op_go_q && hs_err;
        evt_clr = (wr_data && (wr_addr_q == BBA_STATUS_OFS)) ? hwdata[BBA_EVT_W-1:0] : '0;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_q <= BBA_EVT_RST;
            irq_q    <= 1'b0;
        end else if (clk_en) begin
            status_q <= (status_q & ~evt_clr) | evt_set;
            irq_q    <= |(status_q & mask_q);
        end
    end

    assign hrdata        = hrdata_q;
    assign irq           = irq_q;
    assign sum_byte      = result_q;
    assign carry_trigger = carry_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic pass_cfg;
    logic bin_cfg;
    logic dec_cfg;
    assign pass_cfg = (ctrl_q[3:0] == 4'h3) && !ctrl_q[BBA_LO_DEC_BIT] && !ctrl_q[BBA_HI_DEC_BIT];
    assign bin_cfg  = (ctrl_q == 11'h30F);
    assign dec_cfg  = (ctrl_q == 11'h03F) && (left_byte[3:0] < 4'hA)
                      && (oper_q[11:8] < 4'hA);

    sequence s_cmd_go;
        wr_data && (wr_addr_q == BBA_CMD_OFS) && hwdata[BBA_CMD_GO_BIT];
    endsequence

    sequence s_run;
        clk_en && op_go_q;
    endsequence

    sequence s_carry_cmd;
        wr_data && (wr_addr_q == BBA_CMD_OFS) && !op_go_q;
    endsequence

    a_go_starts_run: assert property (s_cmd_go ##1 clk_en |-> op_go_q)
        else $error("go write did not start the adder");
    a_result_latch: assert property (s_run |=> result_q == $past(corr_byte))
        else $error("output latches missed the sum");
    a_carry_link: assert property (s_run |=> carry_q == $past(hi_cout))
        else $error("carry trigger not loaded from top carry");
    a_pass_through: assert property (s_run and pass_cfg |=> result_q == $past(left_byte))
        else $error("pass-through changed data");
    a_binary_add: assert property (s_run and bin_cfg
            |=> result_q == 8'($past(left_byte) + $past(right_byte) + {7'h00, $past(carry_q)}))
        else $error("unaltered digits were modified");
    a_decimal_low: assert property (s_run and dec_cfg and !carry_q
            |=> result_q[3:0] == 4'(($past(left_byte[3:0]) + $past(oper_q[11:8])) % 10))
        else $error("decimal low digit wrong");
    a_sign_flip: assert property (s_run and (ctrl_q == 11'h608) and !carry_q
            |=> result_q[0] == ~$past(oper_q[BBA_OPER_RIGHT_LSB]))
        else $error("invert sign did not flip bit seven");
    a_comp_digit: assert property (s_run and (ctrl_q == 11'h088) and !carry_q
            |=> result_q[3:0] == ~$past(oper_q[11:8]))
        else $error("complement did not invert digit");
    a_hs_flag: assert property (s_run and hs_err |=> status_q[BBA_EVT_HS_BIT])
        else $error("half-sum error not flagged");
    a_irq_level: assert property (clk_en |=> irq == $past(|(status_q & mask_q)))
        else $error("interrupt level wrong");
    // carry trigger only moves on an adder cycle or a clear/preset command
    a_carry_clear: assert property (s_carry_cmd and hwdata[BBA_CMD_CLR_BIT]
            and !hwdata[BBA_CMD_SET_BIT] |=> !carry_q)
        else $error("clear command left the carry set");
    a_carry_preset: assert property (s_carry_cmd and hwdata[BBA_CMD_SET_BIT]
            |=> carry_q)
        else $error("preset command did not set the carry");
    a_carry_hold: assert property (clk_en && !op_go_q
            && !(wr_data && (wr_addr_q == BBA_CMD_OFS)) |=> $stable(carry_q))
        else $error("carry trigger changed without cause");
    a_done_flag: assert property (s_run |=> status_q[BBA_EVT_DONE_BIT])
        else $error("done event not flagged");
    a_low_carry: assert property (s_run and dec_cfg and !carry_q
            |=> lcy_q == ($past(left_byte[3:0]) + $past(oper_q[11:8]) > 9))
        else $error("decimal low digit did not force a carry");
    a_dec_high: assert property (s_run and dec_cfg and !carry_q
            and (left_byte[7:4] < 4'hA) and (oper_q[15:12] < 4'hA)
            |=> result_q[7:4] == 4'(($past(left_byte[7:4]) + $past(oper_q[15:12])
            + ($past(left_byte[3:0]) + $past(oper_q[11:8]) > 9)) % 10))
        else $error("decimal high digit wrong");
    a_sub_low: assert property (s_run and (ctrl_q == 11'h0FF) and carry_q
            and (left_byte[3:0] < 4'hA) and (oper_q[11:8] < 4'hA)
            |=> result_q[3:0] == 4'(($past(left_byte[3:0]) + 10 - $past(oper_q[11:8])) % 10))
        else $error("decimal subtract low digit wrong");
    a_bin_sub: assert property (s_run and (ctrl_q == 11'h0CF)
            |=> result_q == 8'($past(left_byte) + ~$past(right_byte)
            + {7'h00, $past(carry_q)}))
        else $error("binary subtract was corrected");
endmodule : bba_adder
`default_nettype wire

// [bba_digit.sv]
// one four-bit digit slice: true/complement plus six stage, adder, decimal correction
`timescale 1ns/100ps
`default_nettype none
module bba_digit
    import bba_pkg::*;
#(
    parameter int W = 4
) (
    input  wire logic [W-1:0] left_digit,
    input  wire logic [W-1:0] right_digit,
    input  wire logic         left_gate,
    input  wire logic         right_gate,
    input  wire logic         decimal_true,
    input  wire logic         complement,
    input  wire logic         unaltered,
    input  wire logic         carry_in,
    output logic [W-1:0]      sum_out,
    output logic              carry_out
);
    logic [W-1:0] la;
    logic [W-1:0] rb;
    logic [W-1:0] six;
    logic [W:0]   total;
    always_comb begin
        la  = left_gate ? left_digit : '0;
        // unaltered wins over complement so a sign digit is never touched
        rb  = !right_gate ? '0 : (complement && !unaltered) ? ~right_digit : right_digit;
        // no plus six while complementing: ones' complement already equals nines' plus six
        six = (right_gate && decimal_true && !complement && !unaltered) ? BBA_SIX : '0;
        total = {1'b0, la} + {1'b0, rb} + {1'b0, six} + {{W{1'b0}}, carry_in};
        carry_out = total[W];
        // only digits gated decimal are corrected; a carry means the sum is right
        if (decimal_true && !unaltered && !total[W]) begin
            sum_out = total[W-1:0] - BBA_SIX;
        end else begin
            sum_out = total[W-1:0];
        end
    end
endmodule : bba_digit
`default_nettype wire

// [bba_hs_check.sv]
// half-sum parity check of the two input bytes
`timescale 1ns/100ps
`default_nettype none
module bba_hs_check #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] left_byte,
    input  wire logic [W-1:0] right_byte,
    input  wire logic         left_parity,
    input  wire logic         right_parity,
    output logic              hs_error
);
    logic hs_parity;
    always_comb begin
        // odd parity bit of the half sum against the complement of the input parity xor
        hs_parity = ~(^(left_byte ^ right_byte));
        hs_error  = (hs_parity != ~(left_parity ^ right_parity));
    end
endmodule : bba_hs_check
`default_nettype wire

// [bba_pkg.sv]
// constants shared by the decimal byte adder files
package bba_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] BBA_CTRL_OFS    = 8'h00;
    localparam logic [7:0] BBA_OPER_OFS    = 8'h04;
    localparam logic [7:0] BBA_CMD_OFS     = 8'h08;
    localparam logic [7:0] BBA_RESULT_OFS  = 8'h0C;
    localparam logic [7:0] BBA_STATUS_OFS  = 8'h10;
    localparam logic [7:0] BBA_MASK_OFS    = 8'h14;
    // control register fields
    localparam int BBA_CTRL_W         = 11;
    localparam int BBA_LHI_GATE_BIT   = 0;
    localparam int BBA_LLO_GATE_BIT   = 1;
    localparam int BBA_RHI_GATE_BIT   = 2;
    localparam int BBA_RLO_GATE_BIT   = 3;
    localparam int BBA_HI_DEC_BIT     = 4;
    localparam int BBA_LO_DEC_BIT     = 5;
    localparam int BBA_HI_COMP_BIT    = 6;
    localparam int BBA_LO_COMP_BIT    = 7;
    localparam int BBA_HI_BIN_BIT     = 8;
    localparam int BBA_LO_BIN_BIT     = 9;
    localparam int BBA_INV_SIGN_BIT   = 10;
    localparam logic [BBA_CTRL_W-1:0] BBA_CTRL_RST = 11'h000;
    // operand register fields
    localparam int BBA_OPER_LEFT_LSB  = 0;
    localparam int BBA_OPER_RIGHT_LSB = 8;
    localparam int BBA_OPER_LPAR_BIT  = 16;
    localparam int BBA_OPER_RPAR_BIT  = 17;
    localparam logic [17:0] BBA_OPER_RST = 18'h00000;
    // command register bits
    localparam int BBA_CMD_GO_BIT     = 0;
    localparam int BBA_CMD_CLR_BIT    = 1;
    localparam int BBA_CMD_SET_BIT    = 2;
    // result register fields
    localparam int BBA_RES_CARRY_BIT  = 8;
    localparam int BBA_RES_HCY_BIT    = 9;
    localparam int BBA_RES_LCY_BIT    = 10;
    // status and mask layout
    localparam int BBA_EVT_W          = 2;
    localparam int BBA_EVT_DONE_BIT   = 0;
    localparam int BBA_EVT_HS_BIT     = 1;
    localparam logic [BBA_EVT_W-1:0] BBA_EVT_RST = 2'h0;
    // excess-six correction value
    localparam logic [3:0] BBA_SIX = 4'h6;
endpackage : bba_pkg

// [bba_seq_model.sv]
// bus master model standing in for the byte gate sequencer
`timescale 1ns/100ps
`default_nettype none
module bba_seq_model (
    input  wire logic        sys_clk,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h00000000;
    end

    // one single word transfer; ok drops low if the slave never answers
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, adr};
        hwrite <= wr;
        htrans <= 2'h2;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~hwdata;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        rd = hrdata;
        ok = (n < 64);
        // released write data is inverted so a stale word cannot pass for a fresh one
        hwdata <= ~hwdata;
    endtask : xfer
endmodule : bba_seq_model
`default_nettype wire

// [test_bcd_byte_adder_datapath.sv]
// self-checking testbench for the decimal byte adder
`timescale 1ns/100ps
`default_nettype none
module test_bcd_byte_adder_datapath
    import bba_pkg::*;
;
    logic        sys_clk;
    logic        rst_n;
    logic        clk_en;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [7:0]  sum_byte;
    logic        carry_trigger;
    int          errors;
    int          comparisons;

    bba_adder i_bba_adder (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .sum_byte(sum_byte), .carry_trigger(carry_trigger));

    bba_seq_model i_bba_seq_model (.sys_clk(sys_clk), .hreadyout(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk32

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: pin %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_pin

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic ok;
        i_bba_seq_model.xfer(1'b0, a, 32'h00000000, r, ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: read stalled", $time);
            wrap_up();
        end
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        ok;
        i_bba_seq_model.xfer(1'b1, a, d, r, ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: write stalled", $time);
            wrap_up();
        end
    endtask : wr

    // one adder cycle; operand parity is made odd unless bad flips the left one
    task automatic run_op(input logic [10:0] ctrl, input logic [7:0] l, input logic [7:0] r,
                          input logic [2:0] cmd, input logic bad, input logic [10:0] exp);
        logic [31:0] res;
        wr(BBA_CTRL_OFS, {21'h000000, ctrl});
        wr(BBA_OPER_OFS, {14'h0000, ~^r, bad ^ ~^l, r, l});
        wr(BBA_CMD_OFS, {29'h00000000, cmd});
        // latches load one edge after the go write, so the read waits an idle cycle
        @(posedge sys_clk);
        rd(BBA_RESULT_OFS, res);
        chk32(res, {21'h000000, exp}, "result word");
        chk_pin(sum_byte, exp[7:0], "sum latches");
        chk_pin({7'h00, carry_trigger}, {7'h00, exp[8]}, "carry trigger");
    endtask : run_op

    task automatic test_reg_map();
        logic [31:0] r;
        chk_pin({6'h00, hresp, hreadyout}, 8'h01, "bus response");
        wr(8'h18, 32'hFFFFFFFF);
        wr(BBA_RESULT_OFS, 32'hFFFFFFFF);
        for (int a = 0; a < 7; a++) begin
            rd(8'(a * 4), r);
            chk32(r, 32'h00000000, "reset or read-only value");
        end
        wr(BBA_CTRL_OFS, 32'hFFFFFFFF);
        rd(BBA_CTRL_OFS, r);
        chk32(r, 32'h000007FF, "control read back");
        $display("test reg_map done");
    endtask : test_reg_map

    task automatic test_decimal_add();
        run_op(11'h03F, 8'h17, 8'h28, 3'h3, 1'b0, 11'h445);
        run_op(11'h03F, 8'h99, 8'h01, 3'h3, 1'b0, 11'h700);
        run_op(11'h03F, 8'h00, 8'h00, 3'h1, 1'b0, 11'h001);
        $display("test decimal_add done");
    endtask : test_decimal_add

    task automatic test_subtract();
        run_op(11'h0FF, 8'h28, 8'h84, 3'h5, 1'b0, 11'h444);
        run_op(11'h0FF, 8'h17, 8'h07, 3'h1, 1'b0, 11'h309);
        run_op(11'h0CF, 8'h50, 8'h20, 3'h5, 1'b0, 11'h730);
        $display("test subtract done");
    endtask : test_subtract

    task automatic test_pass_paths();
        run_op(11'h30C, 8'hFF, 8'hA5, 3'h3, 1'b0, 11'h0A5);
        run_op(11'h21F, 8'h10, 8'h3C, 3'h3, 1'b0, 11'h04C);
        run_op(11'h608, 8'h00, 8'h3C, 3'h3, 1'b0, 11'h00D);
        run_op(11'h003, 8'h5A, 8'hFF, 3'h3, 1'b0, 11'h05A);
        run_op(11'h30F, 8'h9C, 8'hA7, 3'h5, 1'b0, 11'h744);
        run_op(11'h088, 8'hFF, 8'h35, 3'h3, 1'b0, 11'h00A);
        $display("test pass_paths done");
    endtask : test_pass_paths

    // irq lags status by a cycle; every read below ends late enough to see it
    task automatic test_half_sum_irq();
        logic [31:0] r;
        wr(BBA_STATUS_OFS, 32'h00000003);
        wr(BBA_MASK_OFS, 32'h00000002);
        run_op(11'h03F, 8'h01, 8'h00, 3'h3, 1'b0, 11'h001);
        rd(BBA_STATUS_OFS, r);
        chk32(r, 32'h00000001, "status after clean cycle");
        chk_pin({7'h00, irq}, 8'h00, "irq with done masked");
        run_op(11'h03F, 8'h01, 8'h00, 3'h3, 1'b1, 11'h001);
        rd(BBA_STATUS_OFS, r);
        chk32(r, 32'h00000003, "status after bad parity");
        chk_pin({7'h00, irq}, 8'h01, "irq on half-sum error");
        wr(BBA_STATUS_OFS, 32'h00000002);
        rd(BBA_STATUS_OFS, r);
        chk32(r, 32'h00000001, "status after clear");
        chk_pin({7'h00, irq}, 8'h00, "irq after clear");
        wr(BBA_MASK_OFS, 32'h00000001);
        rd(BBA_MASK_OFS, r);
        chk32(r, 32'h00000001, "mask read back");
        chk_pin({7'h00, irq}, 8'h01, "irq on done");
        $display("test half_sum_irq done");
    endtask : test_half_sum_irq

    initial begin
        errors      = 0;
        comparisons = 0;
        rst_n       = 1'b0;
        clk_en      = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        // hreadyout rises at the first edge after release; look at it one edge later
        repeat (2) @(posedge sys_clk);
        test_reg_map();
        test_decimal_add();
        test_subtract();
        test_pass_paths();
        test_half_sum_irq();
        wrap_up();
    end
endmodule : test_bcd_byte_adder_datapath
`default_nettype wire
